/* File: common/ibf_defs.vh */
// constants for the i2c busy and slave-match flag block
`ifndef IBF_DEFS_VH
`define IBF_DEFS_VH
`define IBF_ADDR_W      10
`define IBF_CLR_INTENDED 1'b0
`define IBF_CLR_ASBUILT  1'b1
`define IBF_BIT_CNT_W   4
`define IBF_BIT_ACK     4'h8
`define IBF_ST_IDLE     3'h0
`define IBF_ST_ADDR1    3'h1
`define IBF_ST_ACK1     3'h2
`define IBF_ST_ADDR2    3'h3
`define IBF_ST_ACK2     3'h4
`define IBF_ST_DATA     3'h5
`define IBF_ST_SKIP     3'h6
`define IBF_TEN_HDR     5'h1E
`endif

/* File: dv/ibf_bus_model.sv */
// i2c master model on the shared bus
`timescale 1ns/1ps
module ibf_bus_model (
  input  wire  clk_sys,
  output logic sclIn,
  output logic sdaDrv,
  input  wire  sdaIn
);
  realtime tgt;
  initial begin
    sclIn = 1;
    sdaDrv = 1;
    tgt = 0.0;
  end
  // quarter steps of the 125 ns link clock, each snapped to a falling clk_sys edge
  task q;
    tgt = tgt + 31.25;
    while ($realtime < tgt) @(negedge clk_sys);
  endtask
  // data bits move sda only mid scl-low so no false start or stop; st and sp move it with scl high
  task st;
    tgt = $realtime;
    q;
    sdaDrv = 1;
    q;
    sclIn = 1;
    q;
    sdaDrv = 0;
    q;
    sclIn = 0;
  endtask
  task sp;
    tgt = $realtime;
    q;
    sdaDrv = 0;
    q;
    sclIn = 1;
    q;
    sdaDrv = 1;
    q;
  endtask
  task wb(input logic [7:0] b, output logic ack);
    integer i;
    tgt = $realtime;
    for (i = 7; i >= 0; i--) begin
      q;
      sdaDrv = b[i];
      q;
      sclIn = 1;
      q;
      q;
      sclIn = 0;
    end
    q;
    sdaDrv = 1;
    q;
    sclIn = 1;
    q;
    ack = !sdaIn;
    q;
    sclIn = 0;
  endtask
endmodule // ibf_bus_model

/* File: dv/ibf_flags_sva.sv */
// checker for the busy and match flags at the block ports
`timescale 1ns/1ps
module ibf_flags_sva (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic peripheralRunControl,
  input wire logic busBusyFlag,
  input wire logic ownAddressMatched,
  input wire logic slaveActive,
  input wire logic sdaOut,
  input wire logic sdaOe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // raw pins; the design adds its own sync latency, hence the ranges
  sequence s_start; $fell(sdaIn) && sclIn && peripheralRunControl; endsequence
  sequence s_stop; $rose(sdaIn) && sclIn && peripheralRunControl; endsequence
  property p_busySet; s_start |-> ##[2:6] busBusyFlag; endproperty
  property p_busyClr; s_stop |-> ##[2:6] !busBusyFlag; endproperty
  property p_busyHold; !peripheralRunControl |=> $stable(busBusyFlag); endproperty
  property p_busyRise; $rose(busBusyFlag) |-> $past(peripheralRunControl); endproperty
  property p_matchStop; s_stop |-> ##[2:8] !ownAddressMatched; endproperty
  property p_active; slaveActive == ownAddressMatched; endproperty
  property p_ackLow; sdaOe |-> !sdaOut; endproperty
  property p_offClr; !peripheralRunControl |=> !ownAddressMatched; endproperty
  a_busySet: assert property (p_busySet) else $error("busy not set");
  a_busyClr: assert property (p_busyClr) else $error("busy not cleared");
  a_busyHold: assert property (p_busyHold) else $error("busy moved");
  a_busyRise: assert property (p_busyRise) else $error("busy rose idle");
  a_matchStop: assert property (p_matchStop) else $error("match kept");
  a_active: assert property (p_active) else $error("slave state off");
  a_ackLow: assert property (p_ackLow) else $error("ack not low");
  a_offClr: assert property (p_offClr) else $error("match in reset");
endmodule // ibf_flags_sva
bind ibf_flags ibf_flags_sva chk (.clk_sys, .rst_b, .sclIn, .sdaIn, .peripheralRunControl,
  .busBusyFlag, .ownAddressMatched, .slaveActive, .sdaOut, .sdaOe);

/* File: dv/ibf_flags_tb_top.sv */
// self-checking bench for the busy and match flags
`timescale 1ns/1ps
`include "ibf_defs.vh"
module ibf_flags_tb_top;
  logic clk_sys = 0, rst_b = 0, peripheralRunControl = 0, tenBitMode = 0, ack;
  logic [`IBF_ADDR_W-1:0] ownAddr = 10'h2A5;
  wire sclIn, sdaDrv, sdaIn, busBusyFlag, ownAddressMatched, slaveActive, sdaOut, sdaOe;
  wire matchB, activeB, sdaOutB, sdaOeB;
  integer num_errors = 0, n_tests = 0, cyc = 0;
  // open drain with pull-up; both devices may pull low
  assign sdaIn = sdaDrv & (sdaOe ? sdaOut : 1'h1) & (sdaOeB ? sdaOutB : 1'h1);
  always #5 clk_sys = ~clk_sys;
  ibf_bus_model bm (.clk_sys, .sclIn, .sdaDrv, .sdaIn);
  ibf_flags uut (.clk_sys, .rst_b, .sclIn, .sdaIn, .peripheralRunControl, .tenBitMode,
    .ownAddr, .busBusyFlag, .ownAddressMatched, .slaveActive, .sdaOut, .sdaOe);
  // second device on the same bus with the as-built clearing
  ibf_flags #(.CLR_MODE(`IBF_CLR_ASBUILT)) uutAsBuilt (.clk_sys, .rst_b, .sclIn, .sdaIn,
    .peripheralRunControl, .tenBitMode, .ownAddr, .busBusyFlag(), .ownAddressMatched(matchB),
    .slaveActive(activeB), .sdaOut(sdaOutB), .sdaOe(sdaOeB));
  task chk(input logic g, input logic e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %0t got %b want %b", $time, g, e);
    end
  endtask
  task run(input logic v);
    @(negedge clk_sys) peripheralRunControl = v;
  endtask
  task settle;
    repeat (8) @(negedge clk_sys);
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task t_off;
    bm.st();
    settle;
    chk(busBusyFlag, 1'h0);
    bm.sp();
    $display("off done");
  endtask
  task t_busy;
    run(1'h1);
    bm.st(); // wait for traffic then poll
    settle;
    chk(busBusyFlag, 1'h1);
    run(1'h0);
    bm.sp();
    settle;
    chk(busBusyFlag, 1'h1);
    run(1'h1); // released again: wait and poll anew
    bm.st();
    bm.sp();
    settle;
    chk(busBusyFlag, 1'h0);
    $display("busy done");
  endtask
  task t_m7;
    chk(busBusyFlag, 1'h0);
    bm.st();
    bm.wb({ownAddr[6:0], 1'h0}, ack);
    chk(ack, 1'h1);
    chk(ownAddressMatched, 1'h1);
    chk(matchB, 1'h1);
    bm.st();
    chk(ownAddressMatched, 1'h1);
    chk(matchB, 1'h0);
    chk(activeB, 1'h0);
    bm.wb(8'h10, ack);
    chk(ownAddressMatched, 1'h0);
    chk(slaveActive, 1'h0);
    bm.sp();
    $display("seven done");
  endtask
  task t_m10;
    @(negedge clk_sys) tenBitMode = 1;
    bm.st();
    bm.wb({`IBF_TEN_HDR, ownAddr[9:8], 1'h0}, ack);
    chk(ack, 1'h1);
    bm.wb(ownAddr[7:0], ack);
    chk(ack, 1'h1);
    chk(slaveActive, 1'h1);
    chk(matchB, 1'h1);
    bm.st();
    bm.wb({`IBF_TEN_HDR, ~ownAddr[9:8], 1'h0}, ack);
    chk(ownAddressMatched, 1'h0);
    chk(matchB, 1'h0);
    chk(activeB, 1'h0);
    bm.st();
    bm.wb({`IBF_TEN_HDR, ownAddr[9:8], 1'h0}, ack);
    bm.wb(ownAddr[7:0], ack);
    bm.st();
    chk(matchB, 1'h1);
    chk(ownAddressMatched, 1'h1);
    bm.wb({`IBF_TEN_HDR, ownAddr[9:8], 1'h1}, ack);
    chk(ack, 1'h1);
    bm.wb(8'hFF, ack);
    chk(ownAddressMatched, 1'h1);
    chk(matchB, 1'h0);
    bm.sp();
    settle;
    chk(ownAddressMatched, 1'h0);
    $display("ten done");
  endtask
  initial begin
    repeat (8) @(negedge clk_sys);
    rst_b = 1;
    chk(busBusyFlag, 1'h0);
    t_off;
    t_busy;
    t_m7;
    t_m10;
    end_sim;
  end
  // bounded run: all traffic is well under this
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_sim;
    end
  end
endmodule // ibf_flags_tb_top

/* File: rtl/ibf_flags.v */
// i2c bus-busy and own-address-matched status flags
// What this block does
// - bus_busy_flag sets on a START and clears on a STOP seen on the bus.
// - with peripheral_run_control low no START or STOP is seen and busy holds its value.
// - after power-up busy reads 0 until run control is 1 and a START or STOP is seen.
// - after one START or STOP following release, busy shows the true bus state.
// - own_address_matched sets on recognising the own address in 7-bit or 10-bit mode.
// - intended clearing is on STOP or on a different slave address, in either mode.
// - as-built 7-bit clears on NACK, STOP or repeated START, not on another address.
// - as-built 10-bit clears on NACK, STOP or another address, not on repeated START.
// - when the match flag clears the block stops acting as an addressed slave.
`timescale 1ns/1ps
`include "ibf_defs.vh"
module ibf_flags #(
  parameter CLR_MODE = `IBF_CLR_INTENDED
) (
  input  wire                  clk_sys,
  input  wire                  rst_b,
  input  wire                  sclIn,
  input  wire                  sdaIn,
  input  wire                  peripheralRunControl,
  input  wire                  tenBitMode,
  input  wire [`IBF_ADDR_W-1:0] ownAddr,
  output reg                   busBusyFlag,
  output reg                   ownAddressMatched,
  output reg                   slaveActive,
  output reg                   sdaOut,
  output reg                   sdaOe
);
  localparam ST_IDLE  = `IBF_ST_IDLE;
  localparam ST_ADDR1 = `IBF_ST_ADDR1;
  localparam ST_ACK1  = `IBF_ST_ACK1;
  localparam ST_ADDR2 = `IBF_ST_ADDR2;
  localparam ST_ACK2  = `IBF_ST_ACK2;
  localparam ST_DATA  = `IBF_ST_DATA;
  localparam ST_SKIP  = `IBF_ST_SKIP;

  wire sclQ;
  wire sclRise;
  wire sclFall;
  wire sdaQ;
  wire sdaRise;
  wire sdaFall;

  // both lines share one latency so their relative order is kept
  ibf_line_sync uScl (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .lineIn  (sclIn),
    .lineQ   (sclQ),
    .rise    (sclRise),
    .fall    (sclFall)
  );

  ibf_line_sync uSda (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .lineIn  (sdaIn),
    .lineQ   (sdaQ),
    .rise    (sdaRise),
    .fall    (sdaFall)
  );

  // detection gated by run control; in reset no condition is seen
  wire startSeen = peripheralRunControl & sclQ & sdaFall;
  wire stopSeen  = peripheralRunControl & sclQ & sdaRise;

  reg [2:0]                 state_q;
  reg [2:0]                 state_d;
  reg [`IBF_BIT_CNT_W-1:0]  bitCnt_q;
  reg [7:0]                 shift_q;
  reg                       tenHit_q;
  reg                       ackDrive_q;

  // shift register takes the synced sda at each synced scl rise
  wire [7:0] shiftNext = {shift_q[6:0], sdaQ};

  // no clear on run control: the flag keeps its last value while held
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      busBusyFlag <= 1'b0;
    end else if (startSeen) begin
      busBusyFlag <= 1'b1;
    end else if (stopSeen) begin
      busBusyFlag <= 1'b0;
    end
  end

  // slots in which the ninth clock is acked by this block
  function ackSlot;
    input [2:0] st;
    begin
      ackSlot = (st == ST_ACK1) || (st == ST_ACK2);
    end
  endfunction

  // address phase tracking
  // gated by run control so no match can set while held in reset
  wire byteDone = peripheralRunControl & sclRise & (bitCnt_q == 4'h7);
  wire addr7Hit = (shiftNext[7:1] == ownAddr[6:0]);
  wire hdrHit   = (shiftNext[7:3] == `IBF_TEN_HDR) & (shiftNext[2:1] == ownAddr[9:8]);
  wire lowHit   = (shiftNext == ownAddr[7:0]);

  reg matchSet;
  reg otherAddr;
  reg nackSeen;
  always @* begin
    state_d   = state_q;
    matchSet  = 1'b0;
    otherAddr = 1'b0;
    nackSeen  = 1'b0;
    case (state_q)
      ST_IDLE:  state_d = ST_IDLE;
      ST_ADDR1: begin
        if (byteDone) begin
          if (!tenBitMode && addr7Hit) begin
            matchSet = 1'b1;
            state_d  = ST_ACK1;
          end else if (tenBitMode && hdrHit) begin
            state_d = ST_ACK1;
          end else begin
            otherAddr = 1'b1;
            state_d   = ST_SKIP;
          end
        end
      end
      ST_ACK1: begin
        if (sclRise) begin
          if (tenBitMode && !tenHit_q && !ownAddressMatched) begin
            state_d = ST_ADDR2;
          end else begin
            state_d = ST_DATA;
          end
        end
      end
      ST_ADDR2: begin
        if (byteDone) begin
          if (lowHit) begin
            matchSet = 1'b1;
            state_d  = ST_ACK2;
          end else begin
            otherAddr = 1'b1;
            state_d   = ST_SKIP;
          end
        end
      end
      ST_ACK2:  if (sclRise) state_d = ST_DATA;
      ST_DATA: begin
        // data bytes are never acked here, so a high ninth bit reads as nack
        if (sclRise && bitCnt_q == `IBF_BIT_ACK && sdaQ && ownAddressMatched) begin
          nackSeen = 1'b1;
        end
      end
      // rest of a frame for another slave is ignored until START or STOP
      ST_SKIP:  state_d = ST_SKIP;
      default:  state_d = ST_IDLE;
    endcase
  end

  // clear sources per mode; set wins over clear in the same cycle
  // as-built 7-bit cannot drop on another address: that always follows a START
  reg matchClr;
  always @* begin
    if (CLR_MODE == `IBF_CLR_INTENDED) begin
      matchClr = stopSeen | otherAddr;
    end else if (!tenBitMode) begin
      matchClr = stopSeen | nackSeen | startSeen;
    end else begin
      matchClr = stopSeen | nackSeen | otherAddr;
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q           <= ST_IDLE;
      bitCnt_q          <= 4'h0;
      shift_q           <= 8'h00;
      tenHit_q          <= 1'b0;
      ownAddressMatched <= 1'b0;
      slaveActive       <= 1'b0;
      ackDrive_q        <= 1'b0;
      sdaOut            <= 1'b0;
      sdaOe             <= 1'b0;
    end else begin
      if (startSeen) begin
        // repeated start in 10-bit mode keeps the header match for reads
        tenHit_q <= ownAddressMatched & tenBitMode;
        state_q  <= ST_ADDR1;
        bitCnt_q <= 4'h0;
      end else if (stopSeen || !peripheralRunControl) begin
        tenHit_q <= 1'b0;
        state_q  <= ST_IDLE;
        bitCnt_q <= 4'h0;
      end else begin
        state_q <= state_d;
        if (sclRise) begin
          shift_q  <= shiftNext;
          bitCnt_q <= (bitCnt_q == `IBF_BIT_ACK) ? 4'h0 : bitCnt_q + 4'h1;
        end
      end
      if (matchSet) begin
        ownAddressMatched <= 1'b1;
      end else if (matchClr || !peripheralRunControl) begin
        ownAddressMatched <= 1'b0;
      end
      // slave role follows the flag exactly
      slaveActive  <= matchSet | (ownAddressMatched & ~(matchClr | ~peripheralRunControl));
      // ack on the ninth clock: low from the fall after bit eight to the next fall
      if (sclFall && ackSlot(state_q)) begin
        ackDrive_q <= 1'b1;
      end else if (sclFall || startSeen || stopSeen || !peripheralRunControl) begin
        ackDrive_q <= 1'b0;
      end
      // registered once more so the enable is a clean flop output
      sdaOut <= 1'b0;
      sdaOe  <= ackDrive_q & peripheralRunControl;
    end
  end
endmodule // ibf_flags

/* File: rtl/ibf_line_sync.v */
// two-flop synchroniser with edge detection on the second stage
`timescale 1ns/1ps
module ibf_line_sync (
  input  wire clk_sys,
  input  wire rst_b,
  input  wire lineIn,
  output reg  lineQ,
  output wire rise,
  output wire fall
);
  reg meta_q;
  reg sync_q;

  // meta_q feeds only sync_q
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      lineQ  <= 1'b1;
    end else begin
      meta_q <= lineIn;
      sync_q <= meta_q;
      lineQ  <= sync_q;
    end
  end

  assign rise = sync_q & ~lineQ;
  assign fall = ~sync_q & lineQ;
endmodule // ibf_line_sync
